// *** inc/cmt_consts.svh ***
// Register offsets, field positions, reset values and counts of the timer
`ifndef CMT_CONSTS_SVH
`define CMT_CONSTS_SVH

`define CMT_ADDR_CLKCTL 16'h5065
`define CMT_ADDR_CTL 16'h50C0
`define CMT_ADDR_CNT 16'h50C1
`define CMT_ADDR_CMP 16'h50C2
`define CMT_ADDR_MSK 16'h50C3
`define CMT_ADDR_FLG 16'h50C4

`define CMT_CLK_GATE_BIT 0
`define CMT_CLK_DIV_LSB 1
`define CMT_CLK_DIV_MSB 3
`define CMT_CTL_RUN_BIT 0
`define CMT_CTL_MODE_BIT 1
`define CMT_CTL_CLEAR_BIT 4
`define CMT_MSK_IE_BIT 0
`define CMT_FLG_MATCH_BIT 0

`define CMT_CMP_RESET 8'h00
`define CMT_CNT_RESET 8'h00
`define CMT_DIV_RESET 3'h0
`define CMT_GATE_RESET 1'h0
`define CMT_MODE_RESET 1'h0
`define CMT_IE_RESET 1'h0
`define CMT_FLG_RESET 1'h0
`define CMT_READ_IDLE 8'h00

`define CMT_PHASE_RESET 5'h00
`define CMT_PHASE_STEP 5'h01
`define CMT_COUNT_STEP 8'h01

`endif

// *** inc/cmt_pkg.sv ***
// Types shared by the compare match timer files
package cmt_pkg;

	typedef enum logic [2:0] {
		REG_NONE,
		REG_CLKCTL,
		REG_CTL,
		REG_CNT,
		REG_CMP,
		REG_MSK,
		REG_FLG
	} cmt_reg_t;

	typedef enum logic {
		RUN_STOPPED,
		RUN_COUNTING
	} cmt_run_t;

	typedef enum logic [2:0] {
		DIV_1,
		DIV_2,
		DIV_4,
		DIV_8,
		DIV_16,
		DIV_32,
		DIV_RSV6,
		DIV_RSV7
	} cmt_div_t;

endpackage

// *** verilog/cmt_divider.sv ***
// Gated prescaler giving one-cycle count enables at 1/1 to 1/32
`timescale 1ns/1ps
`default_nettype none
`include "cmt_consts.svh"

module cmt_divider (
	input wire logic clk,
	input wire logic rst,
	input wire logic gate,
	input wire cmt_pkg::cmt_div_t select,
	output logic tick
);

	logic [4:0] phase;

	// Reserved codes deliver no clock at all
	function automatic logic div_hit(input cmt_pkg::cmt_div_t sel,
		input logic [4:0] ph);
		case (sel)
			cmt_pkg::DIV_1: div_hit = 1'b1;
			cmt_pkg::DIV_2: div_hit = &ph[0:0];
			cmt_pkg::DIV_4: div_hit = &ph[1:0];
			cmt_pkg::DIV_8: div_hit = &ph[2:0];
			cmt_pkg::DIV_16: div_hit = &ph[3:0];
			cmt_pkg::DIV_32: div_hit = &ph[4:0];
			default: div_hit = 1'b0;
		endcase
	endfunction

	// Prescaler holds while the gate is shut, saving toggling
	always_ff @(posedge clk) begin
		if (rst) begin
			phase <= `CMT_PHASE_RESET;
		end else if (gate) begin
			phase <= phase + `CMT_PHASE_STEP;
		end
	end

	assign tick = gate && div_hit(select, phase);

endmodule
`default_nettype wire

// *** verilog/cmt_counter.sv ***
// Eight-bit up-counter with compare, match and clear
`timescale 1ns/1ps
`default_nettype none
`include "cmt_consts.svh"

module cmt_counter (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic clear,
	input wire logic [7:0] compare,
	output logic [7:0] count,
	output logic match
);

	// A clear in the same cycle swallows the tick and its match
	assign match = tick && !clear && (count == compare);

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= `CMT_CNT_RESET;
		end else if (clear) begin
			count <= `CMT_CNT_RESET;
		end else if (match) begin
			count <= `CMT_CNT_RESET;
		end else if (tick) begin
			count <= count + `CMT_COUNT_STEP;
		end
	end

endmodule
`default_nettype wire

// *** verilog/cmt_timer.sv ***
// Top of the compare match timer: registers, run control, flag, request
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cmt_consts.svh"

module cmt_timer (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic IRQ,
	output logic MATCH,
	output logic RUNNING,
	output logic DONE
);

////////////////////////////////////////////////////////////////////////////////

	cmt_pkg::cmt_reg_t wr_sel;
	cmt_pkg::cmt_reg_t rd_sel;
	cmt_pkg::cmt_run_t run_state;
	cmt_pkg::cmt_run_t next_run_state;
	cmt_pkg::cmt_div_t div_sel;
	logic clk_gate;
	logic mode_one_shot;
	logic [7:0] compare;
	logic irq_enable;
	logic match_flag;
	logic next_match_flag;
	logic [7:0] count;
	logic match;
	logic div_tick;
	logic count_tick;
	logic wr_clkctl;
	logic wr_ctl;
	logic wr_cmp;
	logic wr_msk;
	logic wr_flg;
	logic counter_clear;
	logic flag_clear;
	logic one_shot_stop;
	logic [7:0] read_word;

////////////////////////////////////////////////////////////////////////////////

	// Address decode shared by the write and read paths
	function automatic cmt_pkg::cmt_reg_t reg_of(input logic [15:0] a);
		case (a)
			`CMT_ADDR_CLKCTL: reg_of = cmt_pkg::REG_CLKCTL;
			`CMT_ADDR_CTL: reg_of = cmt_pkg::REG_CTL;
			`CMT_ADDR_CNT: reg_of = cmt_pkg::REG_CNT;
			`CMT_ADDR_CMP: reg_of = cmt_pkg::REG_CMP;
			`CMT_ADDR_MSK: reg_of = cmt_pkg::REG_MSK;
			`CMT_ADDR_FLG: reg_of = cmt_pkg::REG_FLG;
			default: reg_of = cmt_pkg::REG_NONE;
		endcase
	endfunction

	assign wr_sel = WR ? reg_of(ADDR) : cmt_pkg::REG_NONE;
	assign rd_sel = RD ? reg_of(ADDR) : cmt_pkg::REG_NONE;

	assign wr_clkctl = (wr_sel == cmt_pkg::REG_CLKCTL);
	assign wr_ctl = (wr_sel == cmt_pkg::REG_CTL);
	assign wr_cmp = (wr_sel == cmt_pkg::REG_CMP);
	assign wr_msk = (wr_sel == cmt_pkg::REG_MSK);
	assign wr_flg = (wr_sel == cmt_pkg::REG_FLG);

	// Clear is a write-only strobe, never stored
	assign counter_clear = wr_ctl && WDATA[`CMT_CTL_CLEAR_BIT];
	assign flag_clear = wr_flg && WDATA[`CMT_FLG_MATCH_BIT];

////////////////////////////////////////////////////////////////////////////////

	// Clock control: gate and divider select
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			clk_gate <= `CMT_GATE_RESET;
		end else if (wr_clkctl) begin
			clk_gate <= WDATA[`CMT_CLK_GATE_BIT];
		end
	end

	// Divider select is loaded on any clock control write, running or stopped; no glitch guard here
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			div_sel <= cmt_pkg::cmt_div_t'(`CMT_DIV_RESET);
		end else if (wr_clkctl) begin
			div_sel <= cmt_pkg::cmt_div_t'(
				WDATA[`CMT_CLK_DIV_MSB:`CMT_CLK_DIV_LSB]);
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// Count mode
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			mode_one_shot <= `CMT_MODE_RESET;
		end else if (wr_ctl) begin
			mode_one_shot <= WDATA[`CMT_CTL_MODE_BIT];
		end
	end

	assign one_shot_stop = match && mode_one_shot;

	// A software write in the same cycle as a one-shot stop wins
	always_comb begin
		next_run_state = run_state;
		unique case (run_state)
			cmt_pkg::RUN_STOPPED: begin
				if (wr_ctl && WDATA[`CMT_CTL_RUN_BIT]) begin
					next_run_state = cmt_pkg::RUN_COUNTING;
				end
			end
			cmt_pkg::RUN_COUNTING: begin
				if (wr_ctl) begin
					next_run_state = WDATA[`CMT_CTL_RUN_BIT] ?
						cmt_pkg::RUN_COUNTING : cmt_pkg::RUN_STOPPED;
				end else if (one_shot_stop) begin
					next_run_state = cmt_pkg::RUN_STOPPED;
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			run_state <= cmt_pkg::RUN_STOPPED;
		end else begin
			run_state <= next_run_state;
		end
	end

	// Stopped timer sees no tick, so only a clear moves the count
	assign count_tick = (run_state == cmt_pkg::RUN_COUNTING) && div_tick;

////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			compare <= `CMT_CMP_RESET;
		end else if (wr_cmp) begin
			compare <= WDATA;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			irq_enable <= `CMT_IE_RESET;
		end else if (wr_msk) begin
			irq_enable <= WDATA[`CMT_MSK_IE_BIT];
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// An enabled match in the clearing cycle still sets the flag
	always_comb begin
		next_match_flag = match_flag;
		if (flag_clear) begin
			next_match_flag = 1'b0;
		end
		if (match && irq_enable) begin
			next_match_flag = 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			match_flag <= `CMT_FLG_RESET;
		end else begin
			match_flag <= next_match_flag;
		end
	end

	// Level request mirrors the flag in the same cycle
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= next_match_flag;
		end
	end

	// Raw event, seen whether or not the request is enabled
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			MATCH <= 1'b0;
		end else begin
			MATCH <= match;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			RUNNING <= 1'b0;
		end else begin
			RUNNING <= (next_run_state == cmt_pkg::RUN_COUNTING);
		end
	end

	// Marks the automatic stop at the end of a one-shot wait
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			DONE <= 1'b0;
		end else begin
			DONE <= one_shot_stop && !wr_ctl;
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// Reserved bits and the clear strobe read as zero
	always_comb begin
		read_word = `CMT_READ_IDLE;
		case (rd_sel)
			cmt_pkg::REG_CLKCTL: begin
				read_word[`CMT_CLK_GATE_BIT] = clk_gate;
				read_word[`CMT_CLK_DIV_MSB:`CMT_CLK_DIV_LSB] = div_sel;
			end
			cmt_pkg::REG_CTL: begin
				read_word[`CMT_CTL_RUN_BIT] =
					(run_state == cmt_pkg::RUN_COUNTING);
				read_word[`CMT_CTL_MODE_BIT] = mode_one_shot;
			end
			cmt_pkg::REG_CNT: begin
				read_word = count;
			end
			cmt_pkg::REG_CMP: begin
				read_word = compare;
			end
			cmt_pkg::REG_MSK: begin
				read_word[`CMT_MSK_IE_BIT] = irq_enable;
			end
			cmt_pkg::REG_FLG: begin
				read_word[`CMT_FLG_MATCH_BIT] = match_flag;
			end
			default: begin
				read_word = `CMT_READ_IDLE;
			end
		endcase
	end

	// Data valid only in the cycle after the read strobe
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			RDATA <= `CMT_READ_IDLE;
		end else begin
			RDATA <= read_word;
		end
	end

////////////////////////////////////////////////////////////////////////////////

	cmt_divider u_divider (
		.clk(CLOCK),
		.rst(RST),
		.gate(clk_gate),
		.select(div_sel),
		.tick(div_tick)
	);

	// Counter register has no write path, so writes to it vanish
	cmt_counter u_counter (
		.clk(CLOCK),
		.rst(RST),
		.tick(count_tick),
		.clear(counter_clear),
		.compare(compare),
		.count(count),
		.match(match)
	);

endmodule
`default_nettype wire

// *** verif/cmt_checker_assertions.sv ***
// Port assertions for the compare match timer
`timescale 1ns/1ps
`default_nettype none
`include "cmt_consts.svh"
module cmt_checker (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic IRQ,
	input wire logic MATCH,
	input wire logic RUNNING,
	input wire logic DONE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	logic rc, wc, wf;
	assign rc = RD && ADDR == `CMT_ADDR_CTL;
	assign wc = WR && ADDR == `CMT_ADDR_CTL;
	assign wf = WR && ADDR == `CMT_ADDR_FLG && WDATA[0];
	////////////////////////////////////////////////////////////////////
	a_read_idle: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data not idle");
	a_clear_reads_zero: assert property (rc |=> !RDATA[4])
		else $error("clear bit read as one");
	a_run_start: assert property (wc && WDATA[0] |=> RUNNING)
		else $error("run write did not start");
	a_run_stop: assert property (wc && !WDATA[0] |=> !RUNNING)
		else $error("stop write did not stop");
	a_run_readback: assert property (rc |=> RDATA[0] == $past(RUNNING))
		else $error("run bit read back wrong");
	a_irq_cause: assert property ($rose(IRQ) |-> MATCH)
		else $error("request without match");
	a_irq_holds: assert property (IRQ && !wf |=> IRQ)
		else $error("request dropped alone");
	a_flag_w1c: assert property (wf |=> !IRQ || MATCH)
		else $error("flag not cleared");
	a_oneshot_stop: assert property (DONE |-> MATCH && !RUNNING)
		else $error("one-shot did not stop");
	a_done_pulse: assert property (DONE |=> !DONE)
		else $error("done longer than one cycle");
	a_match_running: assert property (MATCH |-> $past(RUNNING))
		else $error("match while stopped");
	c_match: cover property (MATCH);
	c_done: cover property (DONE);
	c_irq: cover property ($rose(IRQ));
endmodule
bind cmt_timer cmt_checker chk_u (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
	.MATCH(MATCH), .RUNNING(RUNNING), .DONE(DONE));
`default_nettype wire

// *** verif/cmt_irq_sink.sv ***
// Level-triggered interrupt controller input model
`timescale 1ns/1ps
`default_nettype none
module cmt_irq_sink #(
	parameter logic [7:0] VEC_NUM = 8'h08,
	parameter logic [15:0] VEC_ADDR = 16'h8020
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	output logic pend
);
	// Level mode: pending follows the request, so clearing the source clears it
	always_ff @(posedge clk) begin
		if (rst)
			pend <= 1'b0;
		else
			pend <= req;
	end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the compare match timer
`timescale 1ns/1ps
`default_nettype none
`include "cmt_consts.svh"
module tb;
	logic clock, rst, wr, rd, irq, match, running, done, pend;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, v, v1;
	int n_fail, samples_checked, g;
	cmt_timer dut_u (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .MATCH(match),
		.RUNNING(running), .DONE(done));
	cmt_irq_sink ic_u (.clk(clock), .rst(rst), .req(irq), .pend(pend));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic wr_reg(logic [15:0] a, logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [15:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// Cycles between two match pulses; 200 means none seen
	task automatic gap;
		int i;
		for (i = 0; i < 200 && match !== 1'b1; i++)
			@(negedge clock);
		g = 0;
		do begin
			@(negedge clock);
			g++;
		end while (match !== 1'b1 && g < 200);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	task t_reset;
		logic [15:0] a [7] = '{16'h5065, 16'h50C0, 16'h50C1, 16'h50C2,
			16'h50C3, 16'h50C4, 16'h50C5};
		foreach (a[i]) begin
			rd_reg(a[i]);
			chk("reset value", v, 8'h00);
		end
	endtask
	task t_access;
		wr_reg(`CMT_ADDR_CNT, 8'h55);
		rd_reg(`CMT_ADDR_CNT);
		chk("cnt write", v, 8'h00);
		wr_reg(`CMT_ADDR_CMP, 8'hA5);
		rd_reg(`CMT_ADDR_CMP);
		chk("cmp", v, 8'hA5);
		wr_reg(`CMT_ADDR_CTL, 8'h12);
		rd_reg(`CMT_ADDR_CTL);
		chk("ctl", v, 8'h02);
		wr_reg(`CMT_ADDR_CTL, 8'h00);
	endtask
	task t_gate;
		wr_reg(`CMT_ADDR_CLKCTL, 8'h00);
		wr_reg(`CMT_ADDR_CTL, 8'h11);
		repeat (20) @(posedge clock);
		rd_reg(`CMT_ADDR_CNT);
		chk("gated cnt", v, 8'h00);
		wr_reg(`CMT_ADDR_CTL, 8'h00);
	endtask
	task t_repeat;
		wr_reg(`CMT_ADDR_CLKCTL, 8'h01);
		wr_reg(`CMT_ADDR_FLG, 8'h01);
		wr_reg(`CMT_ADDR_MSK, 8'h01);
		wr_reg(`CMT_ADDR_CMP, 8'h02);
		wr_reg(`CMT_ADDR_CTL, 8'h11);
		gap();
		chk("period", 8'(g), 8'h03);
		chk("irq", {7'h00, irq}, 8'h01);
		chk("pend", {7'h00, pend}, 8'h01);
		wr_reg(`CMT_ADDR_CTL, 8'h00);
		rd_reg(`CMT_ADDR_CNT);
		v1 = v;
		wr_reg(`CMT_ADDR_CMP, 8'hFF);
		repeat (10) @(posedge clock);
		// Run for exactly two ticks, then halt
		wr_reg(`CMT_ADDR_CTL, 8'h01);
		wr_reg(`CMT_ADDR_CTL, 8'h00);
		rd_reg(`CMT_ADDR_CNT);
		chk("resume", v, v1 + 8'h02);
		wr_reg(`CMT_ADDR_FLG, 8'h01);
		rd_reg(`CMT_ADDR_FLG);
		chk("flag", v, 8'h00);
		chk("irq off", {6'h00, irq, pend}, 8'h00);
		wr_reg(`CMT_ADDR_CTL, 8'h11);
		rd_reg(`CMT_ADDR_CNT);
		chk("run clear", v, 8'h01);
		wr_reg(`CMT_ADDR_CTL, 8'h00);
	endtask
	task t_div;
		for (int k = 0; k < 8; k++) begin
			wr_reg(`CMT_ADDR_CTL, 8'h00);
			wr_reg(`CMT_ADDR_CLKCTL, {4'h0, 3'(k), 1'b1});
			wr_reg(`CMT_ADDR_CMP, 8'h00);
			wr_reg(`CMT_ADDR_CTL, 8'h11);
			gap();
			chk("div", 8'(g), k < 6 ? 8'(1 << k) : 8'hC8);
		end
		wr_reg(`CMT_ADDR_CTL, 8'h00);
	endtask
	task t_oneshot;
		int i;
		// Setup in the documented order, mode first while stopped
		wr_reg(`CMT_ADDR_CTL, 8'h02);
		wr_reg(`CMT_ADDR_CLKCTL, 8'h01);
		wr_reg(`CMT_ADDR_FLG, 8'h01);
		wr_reg(`CMT_ADDR_MSK, 8'h00);
		wr_reg(`CMT_ADDR_CTL, 8'h12);
		wr_reg(`CMT_ADDR_CMP, 8'h03);
		wr_reg(`CMT_ADDR_CTL, 8'h03);
		for (i = 0; i < 50 && done !== 1'b1; i++)
			@(negedge clock);
		chk("done", {7'h00, done}, 8'h01);
		chk("stopped", {6'h00, running, irq}, 8'h00);
		repeat (20) @(posedge clock);
		rd_reg(`CMT_ADDR_CNT);
		chk("oneshot cnt", v, 8'h00);
		rd_reg(`CMT_ADDR_FLG);
		chk("masked flag", v, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_access();
		t_gate();
		t_repeat();
		t_div();
		t_oneshot();
		report_and_stop();
	end
	// Whole run needs roughly a thousand cycles
	initial begin
		#(20000 * 40);
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire
